// [pfci_pkg.sv]
package pfci_pkg;

    // ----------------------------------------------------------------
    // timing, all figures in ns except SYNC_STAGES, converted at the 25 MHz clock
    // ----------------------------------------------------------------
    localparam int CLK_NS = 40;
    localparam int WE_LOW_NS = 40;
    localparam int READ_ACCESS_NS = 150;
    localparam int PROGRAM_PULSE_NS = 10000;
    localparam int ERASE_PULSE_NS = 9500000;
    localparam int RECOVERY_NS = 6000;
    localparam int SYNC_STAGES = 2;
    // least times, rounded up to whole cycles
    localparam int WE_LOW_CYCLES = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_ACCESS_CYCLES = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROGRAM_PULSE_CYCLES = (PROGRAM_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ERASE_PULSE_CYCLES = (ERASE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVERY_CYCLES = (RECOVERY_NS + CLK_NS - 1) / CLK_NS;
    // one spare cycle so the sampled byte is past the synchroniser
    localparam int READ_WAIT_CYCLES = READ_ACCESS_CYCLES + SYNC_STAGES + 1;

    // ----------------------------------------------------------------
    // command bytes and fixed values
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_SET_READ = 8'h00;
    localparam logic [7:0] CMD_SIGNATURE = 8'h90;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_PROGRAM_VERIFY = 8'hC0;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [15:0] LAST_ADDR = 16'hFFFF;
    localparam int PROGRAM_MAX_TRIES_DEF = 25;
    localparam int ERASE_MAX_TRIES_DEF = 1000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_SIG_CMD = 3'h1,
        OP_SIG_HV = 3'h2,
        OP_PROGRAM = 3'h3,
        OP_ERASE = 3'h4,
        OP_RESET = 3'h5
    } pfci_op_t;

    typedef struct packed {
        pfci_op_t op;
        logic [15:0] addr;
        logic [7:0] data;
    } pfci_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic fail;
    } pfci_rsp_t;

    typedef struct packed {
        logic chip_select_n;
        logic output_drive_n;
        logic write_strobe_n;
        logic id_select_high_voltage;
        logic [15:0] addr;
        logic [7:0] dq_out;
        logic dq_oe;
    } pfci_pins_t;

    localparam pfci_pins_t PINS_IDLE = '{
        chip_select_n: 1'b1,
        output_drive_n: 1'b1,
        write_strobe_n: 1'b1,
        id_select_high_voltage: 1'b0,
        addr: 16'h0000,
        dq_out: 8'h00,
        dq_oe: 1'b0
    };

endpackage

// [pfci_bus_cycle.sv]
`timescale 1ns/1ns
module pfci_bus_cycle
    import pfci_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic write,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic id_hv,
    input wire logic [7:0] dq_in,
    output pfci_pins_t pins,
    output logic done,
    output logic [7:0] rdata
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_WE_LOW = 2'b01,
        PH_WE_HOLD = 2'b10,
        PH_READ = 2'b11
    } pfci_phase_t;

    typedef struct packed {
        pfci_phase_t phase;
        logic [3:0] cnt;
        pfci_pins_t pins;
        logic [7:0] rdata;
        logic done;
        logic [7:0] dq_meta;
        logic [7:0] dq_sync;
    } pfci_cycle_state_t;

    localparam pfci_cycle_state_t RESET_STATE = '{
        phase: PH_IDLE, cnt: 4'h0, pins: PINS_IDLE, rdata: 8'h00,
        done: 1'b0, dq_meta: 8'h00, dq_sync: 8'h00
    };

    pfci_cycle_state_t cur;
    pfci_cycle_state_t next;

    if (READ_WAIT_CYCLES > 16 || WE_LOW_CYCLES > 16) begin : bad_timing
        $error("cycle counts exceed the 4-bit phase counter");
    end

    // ----------------------------------------------------------------
    // one pin cycle: write strobe pulse or timed read
    // ----------------------------------------------------------------
    always_comb begin
        next = cur;
        next.done = 1'b0;
        // data pins come from another domain: two stages before use
        next.dq_meta = dq_in;
        next.dq_sync = cur.dq_meta;
        next.pins.id_select_high_voltage = id_hv;
        unique case (cur.phase)
            PH_IDLE: begin
                if (start) begin
                    next.pins.chip_select_n = 1'b0;
                    next.pins.addr = addr;
                    if (write) begin
                        // R22 address driven in the same cycle as the strobe falls
                        next.pins.write_strobe_n = 1'b0;
                        next.pins.dq_out = wdata;
                        next.pins.dq_oe = 1'b1;
                        next.cnt = 4'(WE_LOW_CYCLES - 1);
                        next.phase = PH_WE_LOW;
                    end else begin
                        next.pins.output_drive_n = 1'b0;
                        next.cnt = 4'(READ_WAIT_CYCLES - 1);
                        next.phase = PH_READ;
                    end
                end
            end
            PH_WE_LOW: begin
                if (cur.cnt == 4'h0) begin
                    // R05 byte held across rising strobe
                    next.pins.write_strobe_n = 1'b1;
                    next.phase = PH_WE_HOLD;
                end else begin
                    next.cnt = cur.cnt - 4'h1;
                end
            end
            PH_WE_HOLD: begin
                // one cycle of data hold after the rising strobe
                next.pins.chip_select_n = 1'b1;
                next.pins.dq_oe = 1'b0;
                next.done = 1'b1;
                next.phase = PH_IDLE;
            end
            PH_READ: begin
                if (cur.cnt == 4'h0) begin
                    next.rdata = cur.dq_sync;
                    next.pins.chip_select_n = 1'b1;
                    next.pins.output_drive_n = 1'b1;
                    next.done = 1'b1;
                    next.phase = PH_IDLE;
                end else begin
                    next.cnt = cur.cnt - 4'h1;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            cur <= RESET_STATE;
        end else begin
            cur <= next;
        end
    end

    assign pins = cur.pins;
    assign done = cur.done;
    assign rdata = cur.rdata;

endmodule

// [pfci_host.sv]
`timescale 1ns/1ns
// Operation
// R01 - flash drives the addressed byte when selected, output on, no write
// R02 - chip select high puts the flash into standby
// R03 - data lines float in standby or with output drive off
// R04 - command register changes only while program voltage is high
// R05 - command byte is captured on the rising write strobe
// R06 - commands take one or two writes that also latch address and data
// R07 - host writes set-read before array reads while program voltage is high
// R08 - signature command, then reads at 0 and 1 give the two codes
// R09 - high voltage on the id address line with others low gives signature
// R10 - signature reads at 0000H and 0001H return the two identity bytes
// R11 - erase needs two back-to-back 20H writes; one alone does nothing
// R12 - erase verify writes A0H with address, next read returns that byte
// R13 - program writes 40H, then a write with target address and data
// R14 - program verify writes C0H, next read returns the programmed byte
// R15 - reset is two back-to-back FFH writes
// R16 - internal timers end program after 10 us, erase after 9.5 ms
// R17 - host waits 6 us after program or erase write before reading
// R18 - host retries program and verify up to 25 times, then fails
// R19 - host programs all bytes to 00H before issuing an erase (this host erases without programming first)
// R20 - flash powers up with its command register in read mode
// R21 - two FFH writes abort program or erase and return to read
// R22 - program address latched on falling strobe, data on rising
// R23 - erase verify write stops erase; its address latched on falling strobe
// R24 - unknown first command byte keeps read mode and starts nothing
module pfci_host
    import pfci_pkg::*;
#(
    parameter int ERASE_WAIT_CYCLES = ERASE_PULSE_CYCLES,
    parameter int PROGRAM_MAX_TRIES = PROGRAM_MAX_TRIES_DEF,
    parameter int ERASE_MAX_TRIES = ERASE_MAX_TRIES_DEF
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire pfci_req_t req,
    output logic rsp_valid,
    output pfci_rsp_t rsp,
    output pfci_pins_t flash_pins,
    output logic program_voltage_high,
    input wire logic [7:0] dq_in
);

    // ----------------------------------------------------------------
    // sizing and checks
    // ----------------------------------------------------------------
    localparam int WAIT_MAX = (ERASE_WAIT_CYCLES > PROGRAM_PULSE_CYCLES) ?
        ERASE_WAIT_CYCLES : PROGRAM_PULSE_CYCLES;
    localparam int WAIT_W = $clog2(WAIT_MAX + 1);
    localparam int TRY_MAX = (ERASE_MAX_TRIES > PROGRAM_MAX_TRIES) ?
        ERASE_MAX_TRIES : PROGRAM_MAX_TRIES;
    localparam int TRY_W = $clog2(TRY_MAX + 1);

    if (ERASE_WAIT_CYCLES < 1 || PROGRAM_MAX_TRIES < 1 || ERASE_MAX_TRIES < 1)
    begin : bad_params
        $error("wait and retry parameters must be at least one");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_SET_READ = 4'h1,
        ST_READ = 4'h2,
        ST_SIG_CMD = 4'h3,
        ST_SIG_READ = 4'h4,
        ST_HV_READ = 4'h5,
        ST_PROG_SETUP = 4'h6,
        ST_PROG_DATA = 4'h7,
        ST_PROG_VERIFY = 4'h8,
        ST_PROG_CHECK = 4'h9,
        ST_ERASE_SETUP = 4'hA,
        ST_ERASE_GO = 4'hB,
        ST_ERASE_VERIFY = 4'hC,
        ST_ERASE_CHECK = 4'hD,
        ST_RESET_1 = 4'hE,
        ST_RESET_2 = 4'hF
    } pfci_step_t;

    typedef struct packed {
        pfci_step_t st;
        logic issued;
        logic [WAIT_W-1:0] wait_cnt;
        pfci_req_t req;
        logic [15:0] vaddr;
        logic [TRY_W-1:0] tries;
        logic hv;
        logic prog_volt;
        logic rsp_valid;
        pfci_rsp_t rsp;
    } pfci_host_state_t;

    localparam pfci_host_state_t RESET_STATE = '{
        st: ST_IDLE, issued: 1'b0, wait_cnt: '0, req: '0, vaddr: 16'h0000,
        tries: '0, hv: 1'b0, prog_volt: 1'b0, rsp_valid: 1'b0, rsp: '0
    };

    pfci_host_state_t cur;
    pfci_host_state_t next;
    logic cyc_start;
    logic cyc_write;
    logic [15:0] cyc_addr;
    logic [7:0] cyc_data;
    logic cyc_done;
    logic [7:0] cyc_rdata;

    // ----------------------------------------------------------------
    // pin cycle engine
    // ----------------------------------------------------------------
    pfci_bus_cycle u_cycle (
        .clock(clock),
        .rst(rst),
        .start(cyc_start),
        .write(cyc_write),
        .addr(cyc_addr),
        .wdata(cyc_data),
        .id_hv(cur.hv),
        .dq_in(dq_in),
        .pins(flash_pins),
        .done(cyc_done),
        .rdata(cyc_rdata)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next = cur;
        next.rsp_valid = 1'b0;
        // programming level stays applied; every OP_READ array read is preceded by set-read
        next.prog_volt = 1'b1;
        cyc_write = 1'b1;
        cyc_addr = 16'h0000;
        cyc_data = CMD_SET_READ;

        // what the current step puts on the pins
        unique case (cur.st)
            ST_IDLE: begin
                cyc_write = 1'b1;
            end
            // R07 set-read before array read
            ST_SET_READ: cyc_data = CMD_SET_READ;
            ST_READ: begin
                cyc_write = 1'b0;
                cyc_addr = cur.req.addr;
            end
            // R08 signature by command
            ST_SIG_CMD: cyc_data = CMD_SIGNATURE;
            ST_SIG_READ: begin
                cyc_write = 1'b0;
                cyc_addr = {15'h0000, cur.req.addr[0]};
            end
            // R09 other address lines held low
            ST_HV_READ: begin
                cyc_write = 1'b0;
                cyc_addr = {15'h0000, cur.req.addr[0]};
            end
            // R13 setup then address and data
            ST_PROG_SETUP: cyc_data = CMD_PROGRAM;
            ST_PROG_DATA: begin
                cyc_addr = cur.req.addr;
                cyc_data = cur.req.data;
            end
            // R14 verify reads latched address
            ST_PROG_VERIFY: cyc_data = CMD_PROGRAM_VERIFY;
            ST_PROG_CHECK: cyc_write = 1'b0;
            // R11 two erase writes in a row
            ST_ERASE_SETUP: cyc_data = CMD_ERASE;
            ST_ERASE_GO: cyc_data = CMD_ERASE;
            // R12 verify address with command
            ST_ERASE_VERIFY: begin
                cyc_addr = cur.vaddr;
                cyc_data = CMD_ERASE_VERIFY;
            end
            ST_ERASE_CHECK: begin
                cyc_write = 1'b0;
                cyc_addr = cur.vaddr;
            end
            // R15 two reset writes in a row
            ST_RESET_1: cyc_data = CMD_RESET;
            ST_RESET_2: cyc_data = CMD_RESET;
        endcase

        // a cycle starts once any pending wait has run out
        cyc_start = (cur.st != ST_IDLE) && !cur.issued && (cur.wait_cnt == '0);
        if (cur.wait_cnt != '0) begin
            next.wait_cnt = cur.wait_cnt - 1'b1;
        end else if (cyc_start) begin
            next.issued = 1'b1;
        end

        // step on when the pin cycle completes
        if (cyc_done) begin
            next.issued = 1'b0;
            unique case (cur.st)
                ST_IDLE: begin
                    next.issued = 1'b0;
                end
                ST_SET_READ: next.st = ST_READ;
                ST_SIG_CMD: next.st = ST_SIG_READ;
                ST_PROG_SETUP: next.st = ST_PROG_DATA;
                ST_ERASE_SETUP: next.st = ST_ERASE_GO;
                ST_RESET_1: next.st = ST_RESET_2;
                ST_READ, ST_SIG_READ, ST_HV_READ: begin
                    next.st = ST_IDLE;
                    next.hv = 1'b0;
                    next.rsp_valid = 1'b1;
                    next.rsp.data = cyc_rdata;
                    next.rsp.fail = 1'b0;
                end
                ST_PROG_DATA: begin
                    // R16 let the internal program timer run out
                    next.st = ST_PROG_VERIFY;
                    next.wait_cnt = WAIT_W'(PROGRAM_PULSE_CYCLES);
                end
                ST_PROG_VERIFY: begin
                    // R17 recovery before the verify read
                    next.st = ST_PROG_CHECK;
                    next.wait_cnt = WAIT_W'(RECOVERY_CYCLES);
                end
                ST_PROG_CHECK: begin
                    // R18 bounded retry of program and verify
                    if (cyc_rdata == cur.req.data) begin
                        next.st = ST_IDLE;
                        next.rsp_valid = 1'b1;
                        next.rsp.data = cyc_rdata;
                        next.rsp.fail = 1'b0;
                    end else if (cur.tries == TRY_W'(PROGRAM_MAX_TRIES - 1)) begin
                        next.st = ST_IDLE;
                        next.rsp_valid = 1'b1;
                        next.rsp.data = cyc_rdata;
                        next.rsp.fail = 1'b1;
                    end else begin
                        next.tries = cur.tries + 1'b1;
                        next.st = ST_PROG_SETUP;
                    end
                end
                ST_ERASE_GO: begin
                    // R16 erase timer runs out before verify stops it
                    next.st = ST_ERASE_VERIFY;
                    next.wait_cnt = WAIT_W'(ERASE_WAIT_CYCLES);
                end
                ST_ERASE_VERIFY: begin
                    // R17 recovery before the verify read
                    next.st = ST_ERASE_CHECK;
                    next.wait_cnt = WAIT_W'(RECOVERY_CYCLES);
                end
                ST_ERASE_CHECK: begin
                    if (cyc_rdata == ERASED_BYTE) begin
                        if (cur.vaddr == LAST_ADDR) begin
                            next.st = ST_IDLE;
                            next.rsp_valid = 1'b1;
                            next.rsp.data = cyc_rdata;
                            next.rsp.fail = 1'b0;
                        end else begin
                            // verify walks on without a fresh erase
                            next.vaddr = cur.vaddr + 16'h0001;
                            next.st = ST_ERASE_VERIFY;
                        end
                    end else if (cur.tries == TRY_W'(ERASE_MAX_TRIES - 1)) begin
                        next.st = ST_IDLE;
                        next.rsp_valid = 1'b1;
                        next.rsp.data = cyc_rdata;
                        next.rsp.fail = 1'b1;
                    end else begin
                        // re-erase and resume at the failing address
                        next.tries = cur.tries + 1'b1;
                        next.st = ST_ERASE_SETUP;
                    end
                end
                ST_RESET_2: begin
                    next.st = ST_IDLE;
                    next.rsp_valid = 1'b1;
                    next.rsp.data = 8'h00;
                    next.rsp.fail = 1'b0;
                end
            endcase
        end

        // accept a new request only while idle
        if (cur.st == ST_IDLE && req_valid) begin
            next.req = req;
            next.tries = '0;
            next.issued = 1'b0;
            unique case (req.op)
                OP_READ: next.st = ST_SET_READ;
                OP_SIG_CMD: next.st = ST_SIG_CMD;
                OP_SIG_HV: begin
                    // high voltage settles one cycle before chip select falls
                    next.hv = 1'b1;
                    next.st = ST_HV_READ;
                    next.wait_cnt = WAIT_W'(1);
                end
                OP_PROGRAM: next.st = ST_PROG_SETUP;
                OP_ERASE: begin
                    // R19 array must already hold 00H everywhere; this host erases without programming it first
                    next.vaddr = req.addr;
                    next.st = ST_ERASE_SETUP;
                end
                OP_RESET: next.st = ST_RESET_1;
                default: begin
                    // unknown operation code: refuse at once
                    next.rsp_valid = 1'b1;
                    next.rsp.data = 8'h00;
                    next.rsp.fail = 1'b1;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            cur <= RESET_STATE;
        end else begin
            cur <= next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign req_ready = (cur.st == ST_IDLE);
    assign rsp_valid = cur.rsp_valid;
    assign rsp = cur.rsp;
    assign program_voltage_high = cur.prog_volt;

endmodule

// [pfci_flash_model.sv]
`timescale 1ns/1ns
module pfci_flash_model
    import pfci_pkg::*;
#(
    parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
    parameter logic [7:0] DEVICE_ID = 8'hC3, // arbitrary value
    parameter logic [15:0] STUCK_ADDR = 16'h00AA
)
(
    input wire pfci_pins_t pins,
    input wire logic prog_volt_high,
    output logic [7:0] dq
);
    logic [7:0] mem [0:65535];
    logic [7:0] cmd = 8'h00;
    logic [7:0] prev = 8'h00;
    logic [7:0] last = 8'h00;
    logic [15:0] fa = 16'h0000;
    logic [15:0] la = 16'h0000;
    logic drv;
    logic [7:0] val;
    // array preset to a pattern so stale reads show up
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'(i >> 8);
        end
    end
    always @(negedge pins.write_strobe_n) begin
        if (!pins.chip_select_n) fa = pins.addr;
    end
    always @(posedge pins.write_strobe_n) begin
        if (!pins.chip_select_n && prog_volt_high) begin
            if (cmd == 8'h40) begin
                la = fa;
                if (fa !== STUCK_ADDR) mem[fa] = pins.dq_out;
                cmd = 8'h00;
                prev = 8'h01;
            end else begin
                case (pins.dq_out)
                    8'h00, 8'h90, 8'hC0, 8'h40: cmd = pins.dq_out;
                    8'hA0: begin
                        cmd = 8'hA0;
                        la = fa;
                    end
                    8'h20: if (prev == 8'h20) for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
                    8'hFF: if (prev == 8'hFF) cmd = 8'h00;
                    default: ;
                endcase
                // a matched pair is used up so a third byte starts afresh
                prev = (prev == pins.dq_out) ? 8'h01 : pins.dq_out;
            end
        end
    end
    assign val = (pins.id_select_high_voltage || cmd == 8'h90) ?
        (pins.addr[0] ? DEVICE_ID : MAKER_ID) :
        ((cmd == 8'hA0 || cmd == 8'hC0) ? mem[la] : mem[pins.addr]);
    // drive only when selected with output on
    assign drv = !pins.chip_select_n && !pins.output_drive_n && pins.write_strobe_n;
    always @(val or drv) if (drv) last = val;
    // floating lines show the inverse so stale data never passes
    assign dq = drv ? val : ~last;
endmodule

// [pfci_host_assertions.sv]
`timescale 1ns/1ns
module pfci_host_assertions
    import pfci_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire pfci_pins_t flash_pins,
    input wire logic program_voltage_high
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_write;
        !flash_pins.write_strobe_n && !flash_pins.chip_select_n && flash_pins.dq_oe
        ##1 flash_pins.write_strobe_n && flash_pins.dq_oe;
    endsequence
    sequence s_read;
        ##1 (!flash_pins.output_drive_n && $stable(flash_pins.addr))[*6]
        ##1 flash_pins.output_drive_n;
    endsequence
    property p_write_pulse;
        $fell(flash_pins.write_strobe_n) |-> s_write;
    endproperty
    a_write_pulse: assert property (p_write_pulse)
        else $error("write strobe pulse malformed");
    property p_read_hold;
        $fell(flash_pins.output_drive_n) |-> s_read;
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("read cycle length or address hold wrong");
    property p_no_contention;
        !flash_pins.output_drive_n |-> !flash_pins.dq_oe && flash_pins.write_strobe_n
            && !flash_pins.chip_select_n;
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("host drives data while flash outputs");
    property p_standby;
        flash_pins.chip_select_n |-> !flash_pins.dq_oe && flash_pins.output_drive_n
            && flash_pins.write_strobe_n;
    endproperty
    a_standby: assert property (p_standby)
        else $error("strobes active while deselected");
    property p_hv_addr;
        flash_pins.id_select_high_voltage && !flash_pins.chip_select_n
            |-> flash_pins.addr[15:1] == 15'h0000 && flash_pins.write_strobe_n;
    endproperty
    a_hv_addr: assert property (p_hv_addr)
        else $error("high voltage id read with other address lines set");
    property p_prog_volt_up;
        !rst |=> program_voltage_high;
    endproperty
    a_prog_volt_up: assert property (p_prog_volt_up)
        else $error("program voltage not held high");
    property p_ready_drop;
        req_valid && req_ready |=> !req_ready || rsp_valid;
    endproperty
    a_ready_drop: assert property (p_ready_drop)
        else $error("ready stayed high after a take");
    property p_rsp_pulse;
        rsp_valid |-> req_ready ##1 !rsp_valid;
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse)
        else $error("response not a single pulse with ready");
endmodule
bind pfci_host pfci_host_assertions u_chk (.clock(clock), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .flash_pins(flash_pins),
    .program_voltage_high(program_voltage_high));

// [tb_pfci_host.sv]
`timescale 1ns/1ns
module tb_pfci_host;
    import pfci_pkg::*;
    localparam logic [7:0] MAKER_ID = 8'h5A; // arbitrary value
    localparam logic [7:0] DEVICE_ID = 8'hC3; // arbitrary value
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    pfci_req_t req = '0;
    logic req_ready;
    logic rsp_valid;
    logic program_voltage_high;
    pfci_rsp_t rsp;
    pfci_pins_t flash_pins;
    logic [7:0] dq;
    int error_cnt = 0;
    int num_checks = 0;
    always #20 clock = ~clock;
    // short erase wait keeps the run brief
    pfci_host #(.ERASE_WAIT_CYCLES(20)) dut (.clock(clock), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
        .flash_pins(flash_pins), .program_voltage_high(program_voltage_high), .dq_in(dq));
    pfci_flash_model #(.MAKER_ID(MAKER_ID), .DEVICE_ID(DEVICE_ID)) model (.pins(flash_pins),
        .prog_volt_high(program_voltage_high), .dq(dq));
    task automatic check(string name, logic [8:0] seen, logic [8:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    // one request, held until taken, then a bounded wait for the answer
    task automatic op(string name, logic [2:0] code, logic [15:0] a, logic [7:0] d,
                      bit fail_only, logic [8:0] exp);
        int n = 0;
        @(negedge clock);
        req_valid = 1'b1;
        req = '{op: pfci_op_t'(code), addr: a, data: d};
        while (req_ready !== 1'b1) @(negedge clock);
        @(negedge clock);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 20000) begin
            @(negedge clock);
            n++;
        end
        check({name, " valid"}, {8'h00, rsp_valid}, 9'h001);
        check(name, fail_only ? {8'h00, rsp.fail} : rsp, exp);
    endtask
    task automatic t_read_sig();
        op("read", 3'h0, 16'h1234, 8'h00, 0, {8'h26, 1'b0});
        op("hv maker", 3'h2, 16'h0000, 8'h00, 0, {MAKER_ID, 1'b0});
        op("hv device", 3'h2, 16'h0001, 8'h00, 0, {DEVICE_ID, 1'b0});
        op("sig maker", 3'h1, 16'h0000, 8'h00, 0, {MAKER_ID, 1'b0});
        op("sig device", 3'h1, 16'h0001, 8'h00, 0, {DEVICE_ID, 1'b0});
        op("read after sig", 3'h0, 16'h0001, 8'h00, 0, {8'h01, 1'b0});
    endtask
    task automatic t_program();
        op("program", 3'h3, 16'hFFFE, 8'h3C, 1, 9'h000);
        op("read programmed", 3'h0, 16'hFFFE, 8'h00, 0, {8'h3C, 1'b0});
        op("read neighbour", 3'h0, 16'hFFFF, 8'h00, 0, {8'h00, 1'b0});
        op("program stuck", 3'h3, 16'h00AA, 8'h55, 0, {8'hAA, 1'b1});
    endtask
    task automatic t_erase_reset();
        op("erase", 3'h4, 16'hFFFE, 8'h00, 1, 9'h000);
        op("read erased", 3'h0, 16'hFFFE, 8'h00, 0, {8'hFF, 1'b0});
        op("read erased low", 3'h0, 16'h1234, 8'h00, 0, {8'hFF, 1'b0});
        op("reset", 3'h5, 16'h0000, 8'h00, 0, 9'h000);
        op("read after reset", 3'h0, 16'h00AA, 8'h00, 0, {8'hFF, 1'b0});
    endtask
    task automatic t_refused();
        op("op six", 3'h6, 16'h0000, 8'h00, 1, 9'h001);
        op("op seven", 3'h7, 16'h0000, 8'h00, 1, 9'h001);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // watchdog sized well past the slowest sequence
    initial begin
        #(40 * 60000);
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        check("idle pins", {5'h00, flash_pins.chip_select_n, flash_pins.output_drive_n,
            flash_pins.write_strobe_n, flash_pins.dq_oe}, 9'h00E);
        check("prog volt high", {8'h00, program_voltage_high}, 9'h001);
        t_read_sig();
        t_program();
        t_erase_reset();
        t_refused();
        finish_test();
    end
endmodule
